//--- hw/nfc_cmd_frontend.sv
// Purpose: Contactless command front end: activation states, opcode decode, nibble replies.
// Assumes: Received bytes, parity and CRC checks come from a demodulator on i_clk.
// Notes:   Data replies are only requested here; another block builds their payload.
`timescale 1ns/1ps
`default_nettype none
module nfc_cmd_frontend
    import nfc_fe_pkg::*;
#(
    parameter int unsigned TIMEOUT_LIMIT = TIMEOUT_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_data,
    input  wire logic       i_rx_short,
    input  wire logic       i_rx_par_err,
    input  wire logic       i_rx_end,
    input  wire logic       i_rx_crc_err,
    input  wire logic       i_uid_match,
    input  wire logic       i_arb_host,
    input  wire logic       i_arg_bad,
    input  wire logic [2:0] i_pwd_max,
    input  wire logic       i_nvm_done,
    input  wire logic       i_nvm_fail,
    output logic            o_rx_ready,
    output logic [2:0]      o_iso_state,
    output logic [3:0]      o_cmd,
    output logic [7:0]      o_arg,
    output logic            o_data_req,
    output logic            o_nvm_start,
    output logic            o_tx_bit,
    output logic            o_tx_active
);
    typedef struct packed {
        iso_t        st;
        logic        halted;
        phase_t      ph;
        logic [7:0]  b0;
        logic [7:0]  b1;
        logic [1:0]  nb;
        logic        short_f;
        logic        err;
        logic [15:0] cnt;
        cmd_t        cmd;
        logic        nib;
        logic        pend_nvm;
        logic [3:0]  code;
        logic        send;
        logic        data_req;
        logic        nvm_start;
        logic [2:0]  pwd_fails;
    } fe_t;

    fe_t  r;
    fe_t  n;
    cmd_t cmd;
    logic bad_frame;
    logic fr_end;

    reply_if rif ();

    assign cmd       = decode_cmd(r.short_f, r.b0, r.b1, r.nb);
    assign bad_frame = r.err | i_rx_crc_err;
    assign fr_end    = i_ce & i_rx_end & (r.ph == P_RX);

    always_comb begin
        n           = r;
        n.send      = 1'b0;
        n.data_req  = 1'b0;
        n.nvm_start = 1'b0;
        case (r.ph)
            P_RX: begin
                if (i_rx_valid) begin
                    if (r.nb == 2'd0) n.b0 = i_rx_data;
                    if (r.nb == 2'd1) n.b1 = i_rx_data;
                    if (r.nb != 2'd3) n.nb = r.nb + 2'd1;
                    n.short_f = i_rx_short;
                    n.err     = r.err | i_rx_par_err;
                end
                if (i_rx_end) begin
                    n.nb      = 2'd0;
                    n.err     = 1'b0;
                    n.short_f = 1'b0;
                    n.cnt     = 16'd0;
                    n.cmd     = cmd;
                    n.nib     = 1'b0;
                    case (r.st)
                        S_IDLE, S_HALT: begin
                            // A halted tag answers only the wake-up frame; tag opcodes drop.
                            if (!bad_frame && (cmd == C_WAKE ||
                                               (cmd == C_REQ && r.st == S_IDLE))) begin
                                n.halted = (r.st == S_HALT);
                                n.st     = S_READY1;
                                n.ph     = P_WAIT;
                            end
                        end
                        S_READY1: begin
                            if (!bad_frame && cmd == C_AC1) begin
                                n.ph = P_WAIT;
                            end else if (!bad_frame && cmd == C_SEL1 && i_uid_match) begin
                                n.st = S_READY2;
                                n.ph = P_WAIT;
                            end else begin
                                n.st = r.halted ? S_HALT : S_IDLE;
                            end
                        end
                        S_READY2: begin
                            if (!bad_frame && cmd == C_AC2) begin
                                n.ph = P_WAIT;
                            end else if (!bad_frame && cmd == C_SEL2 && i_uid_match) begin
                                n.st = S_ACTIVE;
                                n.ph = P_WAIT;
                            end else begin
                                n.st = r.halted ? S_HALT : S_IDLE;
                            end
                        end
                        S_ACTIVE: begin
                            n.ph  = P_WAIT;
                            n.nib = 1'b1;
                            if (bad_frame) begin
                                n.code = NIB_CRC;
                            end else if (cmd == C_HALT) begin
                                n.st     = S_HALT;
                                n.halted = 1'b1;
                                n.ph     = P_RX;
                            end else if (!is_tag_cmd(cmd)) begin
                                // Anything else leaves the selected state without a reply.
                                n.st = r.halted ? S_HALT : S_IDLE;
                                n.ph = P_RX;
                            end else if (i_arb_host) begin
                                n.code = NIB_ARB;
                            end else if (cmd == C_PWD && i_pwd_max != 3'd0 &&
                                         r.pwd_fails >= i_pwd_max) begin
                                n.code = NIB_PWD_LIMIT;
                            end else if (i_arg_bad) begin
                                n.code = NIB_ARG;
                                if (cmd == C_PWD && r.pwd_fails != 3'd7) begin
                                    n.pwd_fails = r.pwd_fails + 3'd1;
                                end
                            end else if (cmd == C_WRITE || cmd == C_BURST_WRITE) begin
                                n.pend_nvm  = 1'b1;
                                n.nvm_start = 1'b1;
                            end else if (cmd == C_SECTOR) begin
                                n.code = NIB_ACK;
                            end else begin
                                n.nib = 1'b0;
                                if (cmd == C_PWD) n.pwd_fails = 3'd0;
                            end
                        end
                        default: n.st = S_IDLE;
                    endcase
                end
            end
            P_WAIT: begin
                // The delay counts from the end of the reader frame.
                if (r.cnt != 16'hffff) n.cnt = r.cnt + 16'd1;
                if (r.pend_nvm && i_nvm_done) begin
                    n.pend_nvm = 1'b0;
                    n.code     = i_nvm_fail ? NIB_NVM : NIB_ACK;
                end
                if (r.cnt >= 16'(TIMEOUT_LIMIT - 1)) begin
                    // A write that outlives the time-out is answered by silence.
                    n.pend_nvm = 1'b0;
                    n.ph       = P_RX;
                end else if (!r.pend_nvm && r.cnt >= 16'(FDT_CYC - 1)) begin
                    if (r.nib) begin
                        n.send = 1'b1;
                        n.ph   = P_TX;
                    end else begin
                        n.data_req = 1'b1;
                        n.ph       = P_RX;
                    end
                end
            end
            P_TX: begin
                if (!r.send && !rif.busy) n.ph = P_RX;
            end
            default: n.ph = P_RX;
        endcase
    end

    // All-zero reset is idle, listening, with nothing pending.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
        end else if (i_ce) begin
            r <= n;
        end
    end

    assign rif.start   = r.send;
    assign rif.code    = r.code;
    assign o_rx_ready  = (r.ph == P_RX);
    assign o_iso_state = r.st;
    assign o_cmd       = r.cmd;
    assign o_arg       = r.b1;
    assign o_data_req  = r.data_req;
    assign o_nvm_start = r.nvm_start;

    reply_framer u_framer (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_ce        (i_ce),
        .rif         (rif),
        .o_tx_bit    (o_tx_bit),
        .o_tx_active (o_tx_active)
    );

    localparam int FDT_M1 = FDT_CYC - 1;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_request_ready: assert property (fr_end && r.st == S_IDLE && !bad_frame && cmd == C_REQ
                                      |=> r.st == S_READY1)
        else $error("Request frame did not move idle tag to ready.");
    a_halt_ignores_req: assert property (fr_end && r.st == S_HALT && cmd == C_REQ
                                         |=> r.st == S_HALT && r.ph == P_RX)
        else $error("Halted tag reacted to a request frame.");
    a_halt_deactivates: assert property (fr_end && r.st == S_ACTIVE && !bad_frame && cmd == C_HALT
                                         |=> r.st == S_HALT && r.ph == P_RX)
        else $error("Halt frame did not deactivate the tag.");
    a_crc_nak_code: assert property (fr_end && r.st == S_ACTIVE && i_rx_crc_err
                                     |=> r.ph == P_WAIT && r.nib && r.code == 4'h1)
        else $error("CRC error not answered with code 1h.");
    a_arb_nak_code: assert property (fr_end && r.st == S_ACTIVE && !bad_frame &&
                                     is_tag_cmd(cmd) && i_arb_host
                                     |=> r.nib && r.code == 4'h3)
        else $error("Host-held memory not answered with code 3h.");
    a_idle_ignores_tag: assert property (fr_end && r.st != S_ACTIVE && is_tag_cmd(cmd)
                                         |=> r.ph == P_RX && r.st != S_ACTIVE)
        else $error("Tag command honoured outside the selected state.");
    a_reply_not_early: assert property ($rose(o_tx_active) |-> $past(r.cnt, 2) >= 16'(FDT_M1))
        else $error("Reply started before the frame delay.");
    a_wait_bounded: assert property (r.ph == P_WAIT |-> r.cnt < 16'(TIMEOUT_LIMIT))
        else $error("Reply wait ran past the time-out.");
    a_nvm_fail_code: assert property (i_ce && r.ph == P_WAIT && r.pend_nvm && i_nvm_done &&
                                      i_nvm_fail && r.cnt < 16'(TIMEOUT_LIMIT - 1)
                                      |=> r.code == 4'h7 ##[1:1000] rif.start)
        else $error("Failed write not reported with code 7h.");
    a_write_ack_code: assert property (i_ce && r.ph == P_WAIT && r.pend_nvm && i_nvm_done &&
                                       !i_nvm_fail |=> r.code == 4'ha)
        else $error("Successful write not acknowledged with Ah.");

    c_selected: cover property (r.st == S_READY2 ##1 r.st == S_ACTIVE);
    c_nibble_sent: cover property ($fell(o_tx_active));
    c_data_reply: cover property (o_data_req && r.st == S_ACTIVE);
    c_wake_from_halt: cover property (r.st == S_HALT ##1 r.st == S_READY1);
endmodule
`default_nettype wire

//--- common/nfc_fe_pkg.sv
// Purpose: Shared constants, types and decode helpers of the tag command front end.
// Assumes: A 10 MHz system clock and the 13.56 MHz carrier rate for link timing.
// Notes:   Counts are derived from times so a clock change needs one edit.
`default_nettype none
package nfc_fe_pkg;
    localparam logic [7:0] OP_REQ         = 8'h26;
    localparam logic [7:0] OP_WAKE        = 8'h52;
    localparam logic [7:0] OP_CL1         = 8'h93;
    localparam logic [7:0] OP_CL2         = 8'h95;
    localparam logic [7:0] ARG_ANTICOLL   = 8'h20;
    localparam logic [7:0] ARG_SELECT     = 8'h70;
    localparam logic [7:0] OP_HALT        = 8'h50;
    localparam logic [7:0] ARG_HALT       = 8'h00;
    localparam logic [7:0] OP_VERSION     = 8'h60;
    localparam logic [7:0] OP_READ        = 8'h30;
    localparam logic [7:0] OP_BURST_READ  = 8'h3a;
    localparam logic [7:0] OP_WRITE       = 8'ha2;
    localparam logic [7:0] OP_BURST_WRITE = 8'ha6;
    localparam logic [7:0] OP_SECTOR      = 8'hc2;
    localparam logic [7:0] OP_PWD         = 8'h1b;
    localparam logic [7:0] OP_SIG         = 8'h3c;

    localparam logic [3:0] NIB_ACK        = 4'ha;
    localparam logic [3:0] NIB_ARG        = 4'h0;
    localparam logic [3:0] NIB_CRC        = 4'h1;
    localparam logic [3:0] NIB_ARB        = 4'h3;
    localparam logic [3:0] NIB_PWD_LIMIT  = 4'h4;
    localparam logic [3:0] NIB_NVM        = 4'h7;

    localparam int unsigned CLK_KHZ       = 10000;
    localparam int unsigned FC_KHZ        = 13560;
    localparam int unsigned FDT_N         = 9;
    localparam int unsigned FDT_CYC       = ((FDT_N * 128 + 84) * CLK_KHZ + FC_KHZ - 1) / FC_KHZ;
    localparam int unsigned BIT_CYC       = (128 * CLK_KHZ) / FC_KHZ;
    localparam int unsigned TIMEOUT_US    = 5000;
    localparam int unsigned TIMEOUT_CYC   = TIMEOUT_US * CLK_KHZ / 1000;
    localparam int unsigned READER_GAP_US = 87;
    localparam int unsigned FRAME_BITS    = 6;

    typedef enum logic [2:0] {S_IDLE, S_READY1, S_READY2, S_ACTIVE, S_HALT} iso_t;
    typedef enum logic [1:0] {P_RX, P_WAIT, P_TX} phase_t;
    typedef enum logic [3:0] {
        C_NONE, C_REQ, C_WAKE, C_AC1, C_SEL1, C_AC2, C_SEL2, C_HALT, C_VERSION,
        C_READ, C_BURST_READ, C_WRITE, C_BURST_WRITE, C_SECTOR, C_PWD, C_SIG
    } cmd_t;

    function automatic cmd_t decode_cmd(input logic       short_f,
                                        input logic [7:0] b0,
                                        input logic [7:0] b1,
                                        input logic [1:0] nb);
        cmd_t c;
        c = C_NONE;
        if (short_f) begin
            if ({1'b0, b0[6:0]} == OP_REQ) c = C_REQ;
            else if ({1'b0, b0[6:0]} == OP_WAKE) c = C_WAKE;
        end else begin
            case (b0)
                OP_CL1: c = (b1 == ARG_ANTICOLL) ? C_AC1 : ((b1 == ARG_SELECT) ? C_SEL1 : C_NONE);
                OP_CL2: c = (b1 == ARG_ANTICOLL) ? C_AC2 : ((b1 == ARG_SELECT) ? C_SEL2 : C_NONE);
                OP_HALT: c = (nb >= 2'd2 && b1 == ARG_HALT) ? C_HALT : C_NONE;
                OP_VERSION: c = C_VERSION;
                OP_READ: c = C_READ;
                OP_BURST_READ: c = C_BURST_READ;
                OP_WRITE: c = C_WRITE;
                OP_BURST_WRITE: c = C_BURST_WRITE;
                OP_SECTOR: c = C_SECTOR;
                OP_PWD: c = C_PWD;
                OP_SIG: c = C_SIG;
                default: c = C_NONE;
            endcase
        end
        return c;
    endfunction

    function automatic logic is_tag_cmd(input cmd_t c);
        return c >= C_VERSION;
    endfunction
endpackage
`default_nettype wire

//--- common/reply_if.sv
// Purpose: Carries a nibble reply from the command decoder to the reply framer.
// Assumes: Both ends share one clock.
// Notes:   Start is a one-cycle pulse; busy stays high for the whole frame.
`timescale 1ns/1ps
`default_nettype none
interface reply_if;
    logic       start;
    logic [3:0] code;
    logic       busy;
    modport src (output start, output code, input busy);
    modport snk (input start, input code, output busy);
endinterface
`default_nettype wire

//--- hw/reply_framer.sv
// Purpose: Serialises a 4-bit reply as start bit, four code bits and a quiet bit.
// Assumes: One bit period is BIT_CYC system clocks, 128 carrier cycles rounded down to whole clocks.
// Notes:   Code bits leave least significant first.
`timescale 1ns/1ps
`default_nettype none
module reply_framer
    import nfc_fe_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    reply_if.snk      rif,
    output logic      o_tx_bit,
    output logic      o_tx_active
);
    typedef struct packed {
        logic       active;
        logic [2:0] idx;
        logic [6:0] bcnt;
        logic [5:0] sh;
    } frm_t;

    frm_t r;
    frm_t n;

    always_comb begin
        n = r;
        if (!r.active) begin
            if (rif.start) begin
                n.active = 1'b1;
                n.idx    = 3'd0;
                n.bcnt   = 7'd0;
                n.sh     = {1'b0, rif.code, 1'b1};
            end
        end else if (r.bcnt == 7'(BIT_CYC - 1)) begin
            n.bcnt = 7'd0;
            if (r.idx == 3'(FRAME_BITS - 1)) begin
                n.active = 1'b0;
            end else begin
                n.idx = r.idx + 3'd1;
                n.sh  = {1'b0, r.sh[5:1]};
            end
        end else begin
            n.bcnt = r.bcnt + 7'd1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
        end else if (i_ce) begin
            r <= n;
        end
    end

    assign o_tx_bit    = r.active & r.sh[0];
    assign o_tx_active = r.active;
    assign rif.busy    = r.active;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_start_bit_high: assert property ($rose(r.active) |-> o_tx_bit)
        else $error("Reply frame did not open with a start bit.");
    a_end_bit_quiet: assert property (r.active && r.idx == 3'd5 |-> !o_tx_bit)
        else $error("Subcarrier active during the closing bit.");
    a_nibble_length: assert property (r.active |-> r.idx <= 3'd5)
        else $error("Reply frame longer than six bit periods.");
endmodule
`default_nettype wire

//--- test/reader_model.sv
// Purpose: Behavioural reader that sends command frames into the front end's receive group.
// Assumes: Frames are handed over as decoded bytes, one per clock, then an end pulse.
// Notes:   Data is inverted once released so a stale byte is never mistaken for a live one.
`timescale 1ns/1ps
`default_nettype none
module reader_model
    import nfc_fe_pkg::*;
#(
    parameter int unsigned GAP_CYC = 1000
) (
    input  wire logic       i_clk,
    input  wire logic       i_rx_ready,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_short,
    output logic            o_rx_par_err,
    output logic            o_rx_end,
    output logic            o_rx_crc_err,
    output logic            o_uid_match,
    output logic            o_arg_bad
);
    initial begin
        {o_rx_valid, o_rx_short, o_rx_par_err, o_rx_end} = 4'h0;
        {o_rx_crc_err, o_uid_match, o_arg_bad} = 3'h0;
        o_rx_data = 8'h00;
    end

    // Flags are {crc error, uid match, bad argument, parity error on the opcode byte}.
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int nb,
                         input logic sh, input logic [3:0] fl);
        int k;
        k = 0;
        while (i_rx_ready !== 1'b1 && k < 5000) begin
            @(posedge i_clk);
            k++;
        end
        if (k >= 5000) begin
            testbench.n_errors++;
            $display("BAD t=%0t reader never saw the tag listening", $time);
            testbench.complete_run();
        end
        // The gap exceeds the 870 cycles a reader must leave after a reply.
        repeat (GAP_CYC) @(posedge i_clk);
        for (int i = 0; i < nb; i++) begin
            #5;
            o_rx_valid   = 1'b1;
            o_rx_data    = (i == 0) ? b0 : b1;
            o_rx_short   = sh;
            o_rx_par_err = fl[0] && (i == 0);
            @(posedge i_clk);
        end
        // Valid drops, data inverts and one end pulse carrying the check flags rises, all in the same step.
        #5;
        o_rx_valid   = 1'b0;
        o_rx_data    = ~o_rx_data;
        o_rx_short   = 1'b0;
        o_rx_par_err = 1'b0;
        o_rx_end     = 1'b1;
        {o_rx_crc_err, o_uid_match, o_arg_bad} = fl[3:1];
        @(posedge i_clk);
        #5;
        o_rx_end = 1'b0;
        {o_rx_crc_err, o_uid_match, o_arg_bad} = 3'h0;
    endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking run of activation, opcode decode and nibble replies.
// Assumes: A reader model drives frames; memory writes finish eight cycles after start unless muted.
// Notes:   Expected replies queue up in order; a watcher pops one per reply seen.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nfc_fe_pkg::*;
    localparam int unsigned TLIM = 2000;
    logic       i_clk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       i_ce = 1'b1;
    logic       i_arb_host = 1'b0;
    logic       i_nvm_done = 1'b0;
    logic       i_nvm_fail = 1'b0;
    logic       nvm_bad = 1'b0;
    logic       nvm_mute = 1'b0;
    logic [2:0] i_pwd_max = 3'h0;
    logic       i_rx_valid, i_rx_short, i_rx_par_err, i_rx_end, i_rx_crc_err;
    logic       i_uid_match, i_arg_bad;
    logic [7:0] i_rx_data, o_arg;
    logic       o_rx_ready, o_data_req, o_nvm_start, o_tx_bit, o_tx_active;
    logic [2:0] o_iso_state;
    logic [3:0] o_cmd;
    int         n_errors = 0;
    int         n_checks = 0;
    longint     cyc = 0;
    longint     end_cyc = 0;
    logic [7:0] expq[$];

    nfc_cmd_frontend #(.TIMEOUT_LIMIT(TLIM)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_ce(i_ce), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
        .i_rx_short(i_rx_short), .i_rx_par_err(i_rx_par_err), .i_rx_end(i_rx_end),
        .i_rx_crc_err(i_rx_crc_err), .i_uid_match(i_uid_match), .i_arb_host(i_arb_host),
        .i_arg_bad(i_arg_bad), .i_pwd_max(i_pwd_max), .i_nvm_done(i_nvm_done),
        .i_nvm_fail(i_nvm_fail), .o_rx_ready(o_rx_ready), .o_iso_state(o_iso_state),
        .o_cmd(o_cmd), .o_arg(o_arg), .o_data_req(o_data_req), .o_nvm_start(o_nvm_start),
        .o_tx_bit(o_tx_bit), .o_tx_active(o_tx_active));
    reader_model rdr (.i_clk(i_clk), .i_rx_ready(o_rx_ready), .o_rx_valid(i_rx_valid),
        .o_rx_data(i_rx_data), .o_rx_short(i_rx_short), .o_rx_par_err(i_rx_par_err),
        .o_rx_end(i_rx_end), .o_rx_crc_err(i_rx_crc_err), .o_uid_match(i_uid_match),
        .o_arg_bad(i_arg_bad));

    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (i_rx_end && o_rx_ready) end_cyc <= cyc;
    end

    // Memory stand-in: every write not muted finishes after eight cycles, failing on request.
    always @(posedge i_clk) begin
        if (o_nvm_start === 1'b1 && !nvm_mute) begin
            repeat (7) @(posedge i_clk);
            #5 {i_nvm_done, i_nvm_fail} = {1'b1, nvm_bad};
            @(posedge i_clk);
            #5 {i_nvm_done, i_nvm_fail} = 2'h0;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Notes are {1h, command} for a data reply and {0h, code} for a nibble reply.
    function automatic logic [7:0] pop_note();
        return (expq.size() == 0) ? 8'hff : expq.pop_front();
    endfunction

    task automatic check_delay();
        logic ok;
        ok = (cyc - end_cyc >= FDT_CYC) && (cyc - end_cyc <= TLIM);
        check({7'h00, ok}, 8'h01, "delay");
    endtask

    always @(posedge i_clk) begin
        if (o_data_req === 1'b1) begin
            check({4'h1, o_cmd}, pop_note(), "data reply");
            check_delay();
        end
    end

    always begin : nibble_watch
        logic [5:0] b;
        logic [7:0] note;
        @(posedge o_tx_active);
        note = pop_note();
        check_delay();
        for (int i = 0; i < 6; i++) begin
            repeat ((i == 0) ? BIT_CYC / 2 : BIT_CYC) @(negedge i_clk);
            b[i] = o_tx_bit;
        end
        check({6'h00, b[0], b[5]}, 8'h02, "frame ends");
        check({4'h0, b[4:1]}, note, "nibble");
    end

    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input int nb,
                        input logic sh, input logic [3:0] fl, input logic [8:0] exp,
                        input logic [2:0] st);
        int k;
        if (exp[8]) expq.push_back(exp[7:0]);
        rdr.frame(b0, b1, nb, sh, fl);
        check({5'h00, o_iso_state}, {5'h00, st}, "state");
        if (nb == 2) check(o_arg, b1, "argument");
        // Settings change only once the tag listens again, so no reply sees the next ones.
        k = 0;
        while (o_rx_ready !== 1'b1 && k < 5000) begin
            @(posedge i_clk);
            k++;
        end
        if (k >= 5000) begin
            n_errors++;
            $display("BAD t=%0t tag never returned to listening", $time);
            complete_run();
        end
        $display("frame %h %h done", b0, b1);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] ops[4];
        cmd_t       exps[4];
        ops  = '{OP_VERSION, OP_READ, OP_BURST_READ, OP_SIG};
        exps = '{C_VERSION, C_READ, C_BURST_READ, C_SIG};
        void'($urandom(90));
        repeat (12) @(posedge i_clk);
        #5 i_rst_n = 1'b1;
        check({4'h0, o_iso_state, o_rx_ready}, 8'h01, "reset");
        send(OP_REQ, 8'h00, 1, 1'b1, 4'h0, {5'h11, C_REQ}, S_READY1);
        send(OP_CL1, ARG_ANTICOLL, 2, 1'b0, 4'h0, {5'h11, C_AC1}, S_READY1);
        send(OP_CL1, ARG_SELECT, 2, 1'b0, 4'h4, {5'h11, C_SEL1}, S_READY2);
        send(OP_CL2, ARG_ANTICOLL, 2, 1'b0, 4'h0, {5'h11, C_AC2}, S_READY2);
        send(OP_CL2, ARG_SELECT, 2, 1'b0, 4'h4, {5'h11, C_SEL2}, S_ACTIVE);
        for (int i = 0; i < 4; i++) begin
            send(ops[i], 8'($urandom), 2, 1'b0, 4'h0, {5'h11, exps[i]}, S_ACTIVE);
        end
        send(OP_WRITE, 8'($urandom), 2, 1'b0, 4'h0, {5'h10, NIB_ACK}, S_ACTIVE);
        nvm_bad = 1'b1;
        send(OP_BURST_WRITE, 8'h04, 2, 1'b0, 4'h0, {5'h10, NIB_NVM}, S_ACTIVE);
        nvm_bad = 1'b0;
        nvm_mute = 1'b1;
        send(OP_WRITE, 8'h05, 2, 1'b0, 4'h0, 9'h000, S_ACTIVE);
        nvm_mute = 1'b0;
        send(OP_SECTOR, 8'hff, 2, 1'b0, 4'h0, {5'h10, NIB_ACK}, S_ACTIVE);
        send(OP_READ, 8'h04, 2, 1'b0, 4'h8, {5'h10, NIB_CRC}, S_ACTIVE);
        send(OP_READ, 8'h04, 2, 1'b0, 4'h1, {5'h10, NIB_CRC}, S_ACTIVE);
        send(OP_READ, 8'hf0, 2, 1'b0, 4'h2, {5'h10, NIB_ARG}, S_ACTIVE);
        i_arb_host = 1'b1;
        send(OP_READ, 8'h04, 2, 1'b0, 4'h0, {5'h10, NIB_ARB}, S_ACTIVE);
        i_arb_host = 1'b0;
        i_pwd_max = 3'h1;
        send(OP_PWD, 8'h11, 2, 1'b0, 4'h2, {5'h10, NIB_ARG}, S_ACTIVE);
        send(OP_PWD, 8'h11, 2, 1'b0, 4'h0, {5'h10, NIB_PWD_LIMIT}, S_ACTIVE);
        i_pwd_max = 3'h0;
        send(OP_PWD, 8'h11, 2, 1'b0, 4'h0, {5'h11, C_PWD}, S_ACTIVE);
        send(OP_HALT, ARG_HALT, 2, 1'b0, 4'h0, 9'h000, S_HALT);
        send(OP_READ, 8'h04, 2, 1'b0, 4'h0, 9'h000, S_HALT);
        send(OP_REQ, 8'h00, 1, 1'b1, 4'h0, 9'h000, S_HALT);
        send(OP_WAKE, 8'h00, 1, 1'b1, 4'h0, {5'h11, C_WAKE}, S_READY1);
        repeat (TLIM + 1000) @(posedge i_clk);
        check(8'(expq.size()), 8'h00, "replies missing");
        complete_run();
    end
endmodule
`default_nettype wire
